//--- rtl/itd_dma_regs.svh
// Constants of the interrupt-triggered transfer engine
`ifndef ITD_DMA_REGS_SVH
`define ITD_DMA_REGS_SVH

// ==========================================================
// Register port offsets and control bit
`define ITD_OFF_CTRL 8'h00
`define ITD_OFF_STATUS 8'h04
`define ITD_OFF_ESTIMATE 8'h08
`define ITD_OFF_MEASURED 8'h0C
`define ITD_CTRL_ROUTE 0

// ==========================================================
// Transfer setup word fields
`define ITD_M_SIZE16 1
`define ITD_M_SRC_MEM 2
`define ITD_M_SRC_INC 3
`define ITD_M_DST_INC 4
`define ITD_M_ADD 5
`define ITD_M_BURST 6
`define ITD_M_CHAIN 7
`define ITD_M_IRQ_EN 8
`define ITD_M_MULTI 9
`define ITD_M_PQ_LO 10
`define ITD_M_PQ_HI 12

// ==========================================================
// Address space, trigger level and descriptor layout
`define ITD_LOW_LIMIT 32'h0200_0000
`define ITD_HIGH_BASE 32'hFE00_0000
`define ITD_TRIG_LEVEL 3'h7
`define ITD_OFF_COUNT 32'h0000_0002
`define ITD_OFF_FIRST 32'h0000_0004
`define ITD_FIELD_BYTES 32'h0000_0004
`define ITD_PAIR_BYTES 32'h0000_0008
`define ITD_WB_LEN_PLAIN 4'hA
`define ITD_WB_LEN_ADD 4'hE
`define ITD_WB_LEN_COUNT 4'h2
`define ITD_WORD_LEN 4'h4
`define ITD_NO_FIELD 3'h5

// ==========================================================
// Timing figures, in clock cycles
`define ITD_IRQ_DELAY 4'h8
`define ITD_T_BASE 6
`define ITD_T_XFER 26
`define ITD_T_MULTI 2
`define ITD_T_CHAIN 4
`define ITD_T_ADD_FIX 7
`define ITD_T_ADD_INC 8
`define ITD_T_M_BASE 21
`define ITD_T_M_PAIR 11

`endif

//--- rtl/itd_pkg.sv
// Types shared by the interrupt-triggered transfer engine
package itd_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_VEC, S_HDR, S_FLD, S_SRC, S_OPR, S_DST, S_UPD, S_WB, S_CHAIN
  } itd_st_t;

  // ==========================================================
  // Complete engine state
  typedef struct packed {
    itd_st_t st;
    logic [3:0] idx;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [31:0] rd;
    logic [31:0] vec;
    logic [31:0] base;
    logic [15:0] mode;
    logic [15:0] count;
    logic [31:0] source_pointer;
    logic [31:0] addend_pointer;
    logic [31:0] destination_pointer;
    logic [31:0] next_descriptor_pointer;
    logic [31:0] completion_handler_pointer;
    logic [15:0] data;
    logic [2:0] fi;
    logic [2:0] pair;
    logic [3:0] irq_cnt;
    logic irq;
    logic [31:0] irq_addr;
    logic ack;
    logic hold;
    logic route;
    logic [31:0] rdata;
    logic [31:0] est;
    logic [31:0] meas;
  } itd_state_t;

endpackage : itd_pkg

//--- rtl/itd_engine.sv
// Interrupt-triggered descriptor transfer engine
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "itd_dma_regs.svh"

module itd_engine
  import itd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic trig_valid,
  input wire logic [2:0] trig_level,
  input wire logic [31:0] trig_vector_addr,
  output logic trig_ack_q,
  output logic hold_irq_q,
  output logic irq_q,
  output logic [31:0] irq_handler_q,
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [31:0] mem_addr_q,
  output logic [7:0] mem_wdata_q,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata_q
);

  itd_state_t s_q, s_d;

  // ==========================================================
  // Helpers
  // Bus address of a linear pointer; the gap folds onto the high region
  function automatic logic [31:0] itd_phys(input logic [31:0] a);
    if (a >= `ITD_LOW_LIMIT && a < `ITD_HIGH_BASE)
      return a - `ITD_LOW_LIMIT + `ITD_HIGH_BASE;
    return a;
  endfunction : itd_phys

  // Whether a descriptor field is present for this setup word
  function automatic logic itd_need(input logic [2:0] f,
                                    input logic [15:0] m);
    if (m[`ITD_M_MULTI])
      return (f == 3'h0) || (f == 3'h2);
    case (f)
      3'h0: return 1'b1;
      3'h1: return m[`ITD_M_ADD];
      3'h2: return 1'b1;
      3'h3: return m[`ITD_M_CHAIN];
      3'h4: return m[`ITD_M_IRQ_EN];
      default: return 1'b0;
    endcase
  endfunction : itd_need

  // Next present field after f, or none
  function automatic logic [2:0] itd_next(input logic [2:0] f,
                                          input logic [15:0] m);
    logic [2:0] r;
    r = `ITD_NO_FIELD;
    for (int j = 4; j >= 0; j--)
      if (3'(j) > f && itd_need(3'(j), m))
        r = 3'(j);
    return r;
  endfunction : itd_next

  // Byte offset of a field inside the descriptor
  function automatic logic [31:0] itd_off(input logic [2:0] f,
                                          input logic [15:0] m,
                                          input logic [2:0] p);
    logic [31:0] d;
    d = m[`ITD_M_ADD] ? `ITD_OFF_FIRST + 2 * `ITD_FIELD_BYTES
                      : `ITD_OFF_FIRST + `ITD_FIELD_BYTES;
    if (m[`ITD_M_MULTI])
      return `ITD_OFF_FIRST + 32'(p) * `ITD_PAIR_BYTES
             + (f == 3'h2 ? `ITD_FIELD_BYTES : 32'h0);
    case (f)
      3'h0: return `ITD_OFF_FIRST;
      3'h1: return `ITD_OFF_FIRST + `ITD_FIELD_BYTES;
      3'h2: return d;
      3'h3: return d + `ITD_FIELD_BYTES;
      default: return d + `ITD_FIELD_BYTES
                      + (m[`ITD_M_CHAIN] ? `ITD_FIELD_BYTES : 32'h0);
    endcase
  endfunction : itd_off

  // ==========================================================
  // Decoded setup word
  logic size16, src_mem, src_inc, dst_inc, add_mode, burst, chain, irq_en;
  logic multi;
  logic [2:0] pair_quantity;
  logic [31:0] step;
  logic [15:0] imm_data;
  logic [111:0] wb_vec;

  assign size16 = s_q.mode[`ITD_M_SIZE16];
  assign src_mem = s_q.mode[`ITD_M_SRC_MEM];
  assign src_inc = s_q.mode[`ITD_M_SRC_INC];
  assign dst_inc = s_q.mode[`ITD_M_DST_INC];
  assign add_mode = s_q.mode[`ITD_M_ADD];
  assign burst = s_q.mode[`ITD_M_BURST];
  assign chain = s_q.mode[`ITD_M_CHAIN];
  assign irq_en = s_q.mode[`ITD_M_IRQ_EN];
  assign multi = s_q.mode[`ITD_M_MULTI];
  assign pair_quantity = s_q.mode[`ITD_M_PQ_HI:`ITD_M_PQ_LO];
  assign step = size16 ? 32'h0000_0002 : 32'h0000_0001;
  // Immediate operand keeps only the low byte or low half
  assign imm_data = size16 ? s_q.source_pointer[15:0]
                           : {8'h00, s_q.source_pointer[7:0]};
  // Count and pointers in descriptor order for write-back
  assign wb_vec = add_mode ? {s_q.destination_pointer, s_q.addend_pointer, s_q.source_pointer, s_q.count}
                           : {32'h0, s_q.destination_pointer, s_q.source_pointer, s_q.count};

  // ==========================================================
  // Access of the current state: address, direction, byte, length
  logic [31:0] acc_addr;
  logic acc_we;
  logic [7:0] acc_byte;
  logic [3:0] acc_len;
  logic [31:0] off_byte;

  always_comb
  begin
    off_byte = 32'(s_q.idx);
    acc_addr = 32'h0;
    acc_we = 1'b0;
    acc_byte = 8'h00;
    acc_len = `ITD_WORD_LEN;
    case (s_q.st)
      S_VEC: acc_addr = s_q.vec + off_byte;
      S_HDR: acc_addr = s_q.base + off_byte;
      S_FLD: acc_addr = s_q.base
                        + itd_off(s_q.fi, s_q.mode, s_q.pair) + off_byte;
      S_SRC:
      begin
        acc_addr = itd_phys(s_q.source_pointer + off_byte);
        acc_len = size16 ? 4'h2 : 4'h1;
      end
      S_OPR:
      begin
        acc_addr = itd_phys(s_q.addend_pointer + off_byte);
        acc_len = size16 ? 4'h2 : 4'h1;
      end
      S_DST:
      begin
        acc_addr = itd_phys(s_q.destination_pointer + off_byte);
        acc_we = 1'b1;
        acc_byte = s_q.data[{s_q.idx[0], 3'b000} +: 8];
        acc_len = size16 ? 4'h2 : 4'h1;
      end
      S_WB:
      begin
        acc_addr = s_q.base + `ITD_OFF_COUNT + off_byte;
        acc_we = 1'b1;
        acc_byte = wb_vec[{s_q.idx, 3'b000} +: 8];
        acc_len = multi ? `ITD_WB_LEN_COUNT
                : add_mode ? `ITD_WB_LEN_ADD : `ITD_WB_LEN_PLAIN;
      end
      S_CHAIN:
      begin
        acc_addr = s_q.vec + off_byte;
        acc_we = 1'b1;
        acc_byte = s_q.next_descriptor_pointer[{s_q.idx[1:0], 3'b000} +: 8];
      end
      default: acc_len = `ITD_WORD_LEN;
    endcase
  end

  // ==========================================================
  // Next-state logic
  logic is_mem, last;
  logic [31:0] rd_new;
  logic [2:0] nf;
  logic fin_irq;
  itd_st_t xfer_st;
  int est_i;

  always_comb
  begin
    est_i = 0;
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.irq = (s_q.irq_cnt == 4'h1);
    s_d.irq_cnt = (s_q.irq_cnt != 4'h0) ? s_q.irq_cnt - 4'h1 : 4'h0;
    s_d.meas = (s_q.st != S_IDLE) ? s_q.meas + 32'h1 : s_q.meas;
    is_mem = (s_q.st != S_IDLE) && (s_q.st != S_UPD);
    rd_new = s_q.rd;
    rd_new[{s_q.idx[1:0], 3'b000} +: 8] = mem_rdata;
    last = s_q.req && mem_ack && (s_q.idx == acc_len - 4'h1);
    nf = itd_next(s_q.fi, s_q.mode);
    xfer_st = src_mem ? S_SRC : (add_mode ? S_OPR : S_DST);
    fin_irq = 1'b0;

    // Byte handshake shared by every memory state
    if (is_mem)
    begin
      if (!s_q.req)
      begin
        s_d.req = 1'b1;
        s_d.we = acc_we;
        s_d.addr = acc_addr;
        s_d.wdata = acc_byte;
      end
      else if (mem_ack)
      begin
        s_d.req = 1'b0;
        s_d.we = 1'b0;
        s_d.rd = rd_new;
        s_d.idx = last ? 4'h0 : s_q.idx + 4'h1;
      end
    end

    case (s_q.st)
      S_IDLE:
      begin
        s_d.hold = 1'b0;
        if (trig_valid && s_q.route && trig_level == `ITD_TRIG_LEVEL)
        begin
          s_d.ack = 1'b1;
          s_d.vec = trig_vector_addr;
          s_d.meas = 32'h0;
          s_d.st = S_VEC;
        end
      end
      S_VEC:
        if (last)
        begin
          s_d.base = rd_new;
          s_d.st = S_HDR;
        end
      S_HDR:
        if (last)
        begin
          s_d.mode = rd_new[15:0];
          s_d.count = rd_new[31:16];
          s_d.fi = 3'h0;
          s_d.pair = 3'h0;
          s_d.st = S_FLD;
        end
      S_FLD:
        if (last)
        begin
          case (s_q.fi)
            3'h0: s_d.source_pointer = rd_new;
            3'h1: s_d.addend_pointer = rd_new;
            3'h2: s_d.destination_pointer = rd_new;
            3'h3: s_d.next_descriptor_pointer = rd_new;
            default: s_d.completion_handler_pointer = rd_new;
          endcase
          s_d.fi = nf;
          if (nf == `ITD_NO_FIELD)
          begin
            if (s_q.count == 16'h0000)
              s_d.st = S_IDLE;
            else if (multi)
              s_d.st = S_SRC;
            else
            begin
              s_d.st = xfer_st;
              s_d.data = imm_data;
              s_d.hold = burst;
            end
          end
        end
      S_SRC:
        if (last)
        begin
          s_d.data = size16 ? rd_new[15:0] : {8'h00, rd_new[7:0]};
          s_d.st = (add_mode && !multi) ? S_OPR : S_DST;
        end
      S_OPR:
        if (last)
        begin
          s_d.data = size16 ? s_q.data + rd_new[15:0]
                            : {8'h00, s_q.data[7:0] + rd_new[7:0]};
          s_d.st = S_DST;
        end
      S_DST:
        if (last)
        begin
          fin_irq = !multi && irq_en && s_q.count == 16'h0001;
          if (fin_irq)
          begin
            s_d.irq_cnt = `ITD_IRQ_DELAY - 4'h1;
            s_d.irq_addr = s_q.completion_handler_pointer;
          end
          s_d.st = S_UPD;
        end
      S_UPD:
        if (multi && s_q.pair + 3'h1 < pair_quantity)
        begin
          s_d.pair = s_q.pair + 3'h1;
          s_d.fi = 3'h0;
          s_d.st = S_FLD;
        end
        else
        begin
          s_d.count = s_q.count - 16'h0001;
          if (!multi)
          begin
            // Unsigned add wraps past the top to zero
            if (src_mem && src_inc)
              s_d.source_pointer = s_q.source_pointer + step;
            if (add_mode && src_mem && src_inc)
              s_d.addend_pointer = s_q.addend_pointer + step;
            if (dst_inc)
              s_d.destination_pointer = s_q.destination_pointer + step;
          end
          s_d.st = S_WB;
        end
      S_WB:
        if (last)
        begin
          if (!multi && burst && s_q.count != 16'h0000)
          begin
            s_d.st = xfer_st;
            s_d.data = imm_data;
          end
          else if (!multi && chain && s_q.count == 16'h0000)
            s_d.st = S_CHAIN;
          else
            s_d.st = S_IDLE;
        end
      S_CHAIN:
        if (last)
          s_d.st = S_IDLE;
      default: s_d.st = S_IDLE;
    endcase

    // Service-time estimate from the freshly read setup word
    if (s_q.st == S_FLD && last && nf == `ITD_NO_FIELD)
    begin
      if (multi)
        est_i = `ITD_T_M_BASE + (`ITD_T_M_PAIR + int'(!src_inc)
                + int'(!dst_inc)) * int'(pair_quantity);
      else
      begin
        est_i = `ITD_T_XFER - int'(src_mem) + int'(!src_inc)
                + int'(!dst_inc);
        if (add_mode)
          est_i = est_i + (src_inc ? `ITD_T_ADD_INC : `ITD_T_ADD_FIX);
        if (burst)
          est_i = est_i * int'(s_q.count);
        est_i = est_i + `ITD_T_BASE;
        if (s_q.count >= 16'(`ITD_T_MULTI))
          est_i = est_i + `ITD_T_CHAIN + (chain ? `ITD_T_CHAIN : 0);
      end
      s_d.est = 32'(est_i);
    end

    // Register port: control write and one-cycle read data
    if (reg_we && reg_addr == `ITD_OFF_CTRL)
      s_d.route = reg_wdata[`ITD_CTRL_ROUTE];
    s_d.rdata = 32'h0;
    if (reg_re)
      case (reg_addr)
        `ITD_OFF_CTRL: s_d.rdata = {31'h0, s_q.route};
        `ITD_OFF_STATUS: s_d.rdata = {s_q.count, 13'h0, s_q.irq_cnt != 4'h0,
                                      s_q.hold, s_q.st != S_IDLE};
        `ITD_OFF_ESTIMATE: s_d.rdata = s_q.est;
        `ITD_OFF_MEASURED: s_d.rdata = s_q.meas;
        default: s_d.rdata = 32'h0;
      endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Outputs straight from the state register
  assign trig_ack_q = s_q.ack;
  assign hold_irq_q = s_q.hold;
  assign irq_q = s_q.irq;
  assign irq_handler_q = s_q.irq_addr;
  assign mem_req_q = s_q.req;
  assign mem_we_q = s_q.we;
  assign mem_addr_q = s_q.addr;
  assign mem_wdata_q = s_q.wdata;
  assign reg_rdata_q = s_q.rdata;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_TRIG_LEVEL: assert property (
    trig_ack_q |-> $past(trig_level) == `ITD_TRIG_LEVEL && $past(s_q.route))
    else $error("engine started by a request not at level 7");

  AST_NO_GAP: assert property (
    mem_req_q |-> !(mem_addr_q >= `ITD_LOW_LIMIT
                    && mem_addr_q < `ITD_HIGH_BASE))
    else $error("bus access fell into the unmapped gap");

  AST_ZERO_COUNT: assert property (
    s_q.st inside {S_SRC, S_OPR, S_DST} |-> s_q.count != 16'h0000)
    else $error("data moved with a zero count");

  AST_COUNT_DOWN: assert property (
    s_q.st == S_UPD && !multi |=> s_q.count == $past(s_q.count) - 16'h1)
    else $error("count did not drop by one per transfer");

  AST_SRC_STEP: assert property (
    s_q.st == S_UPD && !multi && src_mem && src_inc
    |=> s_q.source_pointer == $past(s_q.source_pointer) + $past(step))
    else $error("source pointer step wrong");

  AST_DST_FIXED: assert property (
    s_q.st == S_UPD && !dst_inc |=> $stable(s_q.destination_pointer))
    else $error("fixed destination pointer moved");

  AST_IMM_DATA: assert property (
    mem_req_q && s_q.st == S_DST && !src_mem && !add_mode && !multi
    |-> mem_wdata_q == (s_q.idx[0] ? s_q.source_pointer[15:8] : s_q.source_pointer[7:0]))
    else $error("immediate data not taken from low bytes");

  AST_BURST_HOLD: assert property (
    s_q.st inside {S_SRC, S_OPR, S_DST} && burst && !multi |-> hold_irq_q)
    else $error("interrupts not held off during burst");

  AST_IRQ_DELAY: assert property (
    fin_irq |-> ##8 irq_q && irq_handler_q == $past(s_q.completion_handler_pointer, 8))
    else $error("completion interrupt not on eighth cycle");

  AST_CHAIN_TARGET: assert property (
    mem_req_q && s_q.st == S_CHAIN |-> mem_we_q
    && mem_addr_q == s_q.vec + 32'(s_q.idx))
    else $error("chain update not written to the vector entry");

endmodule : itd_engine

//--- sim/itd_mem_model.sv
// Byte memory partner on the engine's bus
`timescale 1ns/1ps

module itd_mem_model
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic mem_req_q,
  input wire logic mem_we_q,
  input wire logic [31:0] mem_addr_q,
  input wire logic [7:0] mem_wdata_q,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [logic [31:0]];
  int lat = 0;
  int w = 0;

  // Idle data starts known
  initial mem_rdata = 8'h00;

  // ==========================
  // Access after lat waits
  always @(posedge clock)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // Bus not driven: no stale byte
    if (!rstn)
      w <= 0;
    else if (mem_req_q && !mem_ack)
    begin
      if (w < lat)
        w <= w + 1;
      else
      begin
        w <= 0;
        mem_ack <= 1'b1;
        if (mem_we_q)
          mem[mem_addr_q] = mem_wdata_q;
        else
          mem_rdata <= mem.exists(mem_addr_q) ? mem[mem_addr_q] : 8'h00;
      end
    end
  end
endmodule : itd_mem_model

//--- sim/tb.sv
// Self-checking bench of the interrupt-triggered transfer engine
`timescale 1ns/1ps
`include "itd_dma_regs.svh"

module tb;
  logic clock, rstn, trig_valid, trig_ack_q, hold_irq_q, irq_q;
  logic mem_req_q, mem_we_q, mem_ack, reg_we, reg_re, in_burst;
  logic [2:0] trig_level;
  logic [7:0] mem_wdata_q, mem_rdata, reg_addr;
  logic [31:0] trig_vector_addr, irq_handler_q, mem_addr_q, reg_wdata;
  logic [31:0] reg_rdata_q, r, h_seen;
  int n_errors = 0, num_checks = 0, cyc = 0, n_irq = 0, t_w = 0, gap = 0;
  int bad_hold = 0;

  itd_engine i_dut (.clock(clock), .rstn(rstn), .trig_valid(trig_valid),
    .trig_level(trig_level), .trig_vector_addr(trig_vector_addr),
    .trig_ack_q(trig_ack_q), .hold_irq_q(hold_irq_q), .irq_q(irq_q),
    .irq_handler_q(irq_handler_q), .mem_req_q(mem_req_q),
    .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata_q(reg_rdata_q));

  itd_mem_model i_mem (.clock(clock), .rstn(rstn), .mem_req_q(mem_req_q),
    .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // Clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Cycle count, last data write, completion and hold monitors
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (mem_ack && mem_we_q && mem_addr_q == 32'h0000_2105)
      t_w <= cyc;
    if (irq_q === 1'b1)
    begin
      n_irq++;
      gap = cyc - t_w;
      h_seen = irq_handler_q;
    end
    if (in_burst && mem_ack && mem_we_q && mem_addr_q[31:8] == 24'h21
        && hold_irq_q !== 1'b1)
      bad_hold++;
  end

  // Hang guard
  initial
  begin
    wait (cyc == 40000);
    n_errors++;
    finish_test();
  end

  // ==========================
  // Helpers
  task automatic ck(string s, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : ck

  task automatic put(logic [31:0] a, logic [31:0] v, int n);
    for (int i = 0; i < n; i++)
      i_mem.mem[a + i] = v[8 * i +: 8];
  endtask : put

  function automatic logic [31:0] get(logic [31:0] a, int n);
    get = 32'h0;
    for (int i = 0; i < n; i++)
      get[8 * i +: 8] = i_mem.mem[a + i];
  endfunction : get

  // Descriptor: setup word, count, four pointer fields
  task automatic desc(logic [31:0] b, logic [15:0] m, logic [15:0] c,
                      logic [31:0] f0, f1, f2, f3);
    put(b, m, 2);
    put(b + 2, c, 2);
    put(b + 4, f0, 4);
    put(b + 8, f1, 4);
    put(b + 12, f2, 4);
    put(b + 16, f3, 4);
  endtask : desc

  task automatic rw(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask : rw

  task automatic rr(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clock);
    reg_re <= 1'b0;
    @(negedge clock);
    d = reg_rdata_q;
  endtask : rr

  // Request until taken, then poll busy until the engine rests
  task automatic fire(logic [31:0] v, logic [2:0] lv, logic ea);
    logic got;
    logic [31:0] s;
    got = 1'b0;
    s = 32'h1;
    @(posedge clock);
    trig_vector_addr <= v;
    trig_level <= lv;
    trig_valid <= 1'b1;
    for (int k = 0; k < 20 && !got; k++)
    begin
      @(posedge clock);
      got = (trig_ack_q === 1'b1);
    end
    trig_valid <= 1'b0;
    ck("ack", ea, got);
    for (int k = 0; k < 400 && s[0] === 1'b1; k++)
      rr(`ITD_OFF_STATUS, s);
    ck("busy", 32'h0, s[0]);
  endtask : fire

  // ==========================
  // Scenarios
  task automatic t_regs();
    rr(`ITD_OFF_CTRL, r);
    ck("ctrl", 32'h0, r);
    rw(8'h40, 32'hFFFF_FFFF);
    rr(8'h40, r);
    ck("unmapped", 32'h0, r);
    put(32'h100, 32'h400, 4);
    fire(32'h100, 3'h7, 1'b0);
    rw(`ITD_OFF_CTRL, 32'h1);
    rr(`ITD_OFF_CTRL, r);
    ck("ctrl set", 32'h1, r);
    fire(32'h100, 3'h6, 1'b0);
  endtask : t_regs

  // Mid-run reset drops routing, so a level-7 request is ignored
  task automatic t_reset();
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rr(`ITD_OFF_CTRL, r);
    ck("ctrl reset", 32'h0, r);
    fire(32'h100, 3'h7, 1'b0);
  endtask : t_reset

  task automatic t_single();
    desc(32'h400, 16'h001C, 16'h0002, 32'h1000, 32'h2000, 32'h0, 32'h0);
    put(32'h1000, 32'h77A5, 2);
    put(32'h2000, 32'h5A5A5A, 3);
    fire(32'h100, 3'h7, 1'b1);
    ck("byte", 32'hA5, get(32'h2000, 1));
    ck("one only", 32'h5A, get(32'h2001, 1));
    ck("count", 32'h1, get(32'h402, 2));
    ck("src", 32'h1001, get(32'h404, 4));
    ck("dst", 32'h2001, get(32'h408, 4));
    rr(`ITD_OFF_ESTIMATE, r);
    ck("est", 32'h23, r);
    fire(32'h100, 3'h7, 1'b1);
    ck("next", 32'h77, get(32'h2001, 1));
    fire(32'h100, 3'h7, 1'b1);
    ck("zero", 32'h5A, get(32'h2002, 1));
    rr(`ITD_OFF_MEASURED, r);
    ck("measured", 32'h30, r);
  endtask : t_single

  task automatic t_burst();
    i_mem.lat = 2;
    desc(32'h440, 16'h0152, 16'h0003, 32'hDEAD_BEEF, 32'h2100,
         32'h8000_1234, 32'h0);
    put(32'h104, 32'h440, 4);
    in_burst = 1'b1;
    fire(32'h104, 3'h7, 1'b1);
    in_burst = 1'b0;
    for (int i = 0; i < 3; i++)
      ck("word", 32'hBEEF, get(32'h2100 + 2 * i, 2));
    ck("count", 32'h0, get(32'h442, 2));
    ck("dst", 32'h2106, get(32'h448, 4));
    ck("hold", 32'h0, bad_hold);
    ck("irqs", 32'h1, n_irq);
    ck("handler", 32'h8000_1234, h_seen);
    ck("delay", 32'h8, gap);
    rr(`ITD_OFF_ESTIMATE, r);
    ck("est", 32'h5B, r);
    i_mem.lat = 0;
  endtask : t_burst

  task automatic t_add();
    desc(32'h480, 16'h003C, 16'h0001, 32'h1100, 32'h1200, 32'h1300, 32'h0);
    put(32'h1100, 32'hF0, 1);
    put(32'h1200, 32'h20, 1);
    put(32'h108, 32'h480, 4);
    fire(32'h108, 3'h7, 1'b1);
    ck("sum", 32'h10, get(32'h1300, 1));
    ck("addend", 32'h1201, get(32'h488, 4));
    desc(32'h4C0, 16'h0038, 16'h0001, 32'hAB55, 32'h1210, 32'h1310, 32'h0);
    put(32'h1210, 32'h11, 1);
    put(32'h10C, 32'h4C0, 4);
    fire(32'h10C, 3'h7, 1'b1);
    ck("imm sum", 32'h66, get(32'h1310, 1));
    ck("addend", 32'h1210, get(32'h4C8, 4));
    ck("dst", 32'h1311, get(32'h4CC, 4));
  endtask : t_add

  task automatic t_chain();
    desc(32'h500, 16'h009C, 16'h0001, 32'h1000, 32'h1700, 32'h540, 32'h0);
    desc(32'h540, 16'h001C, 16'h0001, 32'h1001, 32'h1701, 32'h0, 32'h0);
    put(32'h110, 32'h500, 4);
    fire(32'h110, 3'h7, 1'b1);
    ck("vector", 32'h540, get(32'h110, 4));
    fire(32'h110, 3'h7, 1'b1);
    ck("chained", 32'h77, get(32'h1701, 1));
  endtask : t_chain

  task automatic t_multi();
    desc(32'h580, 16'h0A04, 16'h0001, 32'h1000, 32'h1800, 32'h1001,
         32'h1810);
    put(32'h114, 32'h580, 4);
    fire(32'h114, 3'h7, 1'b1);
    ck("pair1", 32'hA5, get(32'h1800, 1));
    ck("pair2", 32'h77, get(32'h1810, 1));
    rr(`ITD_OFF_ESTIMATE, r);
    ck("est", 32'h2F, r);
  endtask : t_multi

  task automatic t_wrap();
    desc(32'h5C0, 16'h0056, 16'h0002, 32'h1600, 32'hFFFF_FFFF, 32'h0, 32'h0);
    put(32'h1600, 32'h3412, 2);
    put(32'h118, 32'h5C0, 4);
    fire(32'h118, 3'h7, 1'b1);
    ck("top", 32'h12, get(32'hFFFF_FFFF, 1));
    ck("wrap", 32'h341234, get(32'h0, 3));
    ck("dst", 32'h3, get(32'h5C8, 4));
    desc(32'h600, 16'h005C, 16'h0002, 32'h1000, 32'h01FF_FFFF, 32'h0, 32'h0);
    put(32'h11C, 32'h600, 4);
    fire(32'h11C, 3'h7, 1'b1);
    ck("low end", 32'hA5, get(32'h01FF_FFFF, 1));
    ck("high", 32'h77, get(32'hFE00_0000, 1));
    ck("linear", 32'h0200_0001, get(32'h608, 4));
  endtask : t_wrap

  task automatic finish_test();
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Reset, then every scenario in turn
  initial
  begin
    rstn = 1'b0;
    trig_valid = 1'b0;
    trig_level = 3'h0;
    trig_vector_addr = 32'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    in_burst = 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_single();
    t_burst();
    t_add();
    t_chain();
    t_multi();
    t_wrap();
    t_reset();
    finish_test();
  end
endmodule : tb
